// File: src/ras_pkg.sv
// Shared constants and carrier types of the return address stack unit
package ras_pkg;
  // ==========================================================
  // Geometry
  localparam int PC_W = 21;
  localparam int PTR_W = 5;
  localparam logic [PTR_W-1:0] PTR_TOP = 5'h1F;
  localparam logic [PTR_W-1:0] PTR_NEAR_TOP = 5'h1E;
  localparam logic [PTR_W-1:0] PTR_EMPTY = 5'h00;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [PC_W-1:0] PC_ZERO = 21'h000000;
  // ==========================================================
  // Register map (byte addresses)
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFS_STACK_PTR = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_TOP_LOW = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_TOP_HIGH = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_TOP_UPPER = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 5'h10;
  // ==========================================================
  // Fields
  localparam int FULL_BIT = 7;
  localparam int UNF_BIT = 6;
  localparam int FAULT_EN_BIT = 0;
  localparam logic FAULT_EN_RESET = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic push;
    logic pop;
    logic discard;
    logic vector;
    logic fast;
    logic [PC_W-1:0] pc;
  } ras_core_req_t;
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] working_register;
    logic [7:0] bank_select_register;
  } ras_ctx_t;
endpackage

// File: src/ras_stack.sv
// Return address stack with flags, top-of-stack window and one-level fast shadow context
// ==========================================================
// Summary of operation
// RULE1: Top-entry registers read/write selected stack entry
// RULE2: Call or interrupt push visible at top immediately
// RULE3: Software masks interrupts while touching top entry
// RULE4: Pointer 0..31, zero after reset, software accessible
// RULE5: Increment before push write, decrement after pop
// RULE6: Thirty-first push sets full flag
// RULE7: Fault reset on: store PC+2, flag, reset
// RULE8: Fault reset off: pointer stays 31, no overwrite
// RULE9: Empty pop returns zero, sets underflow, pointer zero
// RULE10: Underflow without fault reset keeps registers intact
// RULE11: Fault reset option: flag first, then reset
// RULE12: Flags bits 7,6 clear only by software/power-on
// RULE13: Bits 4:0 pointer, bit 5 reads zero
// RULE14: Software push stores current PC at new top
// RULE15: Software pop discards top by decrementing
// RULE16: Hidden shadow context loaded on every interrupt vector
// RULE17: Fast interrupt return restores shadow context
// RULE18: Fast call saves context, fast return restores
// RULE19: Software saves context in low-priority nested handlers
// RULE20: Thirty-one 21-bit entries, 5-bit pointer
// RULE21: Returns pop top entry into program counter
// RULE22: Writing one to flags has no effect
//
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module ras_stack
  import ras_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic dev_rst_i,
  input wire ras_core_req_t core_req_i,
  input wire ras_ctx_t ctx_i,
  output logic ret_valid_o,
  output logic [PC_W-1:0] ret_pc_o,
  output logic ctx_restore_o,
  output ras_ctx_t ctx_o,
  output logic fault_reset_o,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);

  // ==========================================================
  // Storage
  // Entry 0 exists only as a pointer value; it is never written
  logic [PC_W-1:0] entries [1:31]; // [RULE20]
  logic [PTR_W-1:0] sp;
  logic full_flag;
  logic unf_flag;
  logic fault_en;
  ras_ctx_t shadow;
  logic [PC_W-1:0] top_entry;

  assign top_entry = (sp == PTR_EMPTY) ? PC_ZERO : entries[sp]; // [RULE1]

  // ==========================================================
  // Bus write channel capture
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane0;
  logic wr_fire;

  assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_held && !s_axi_bvalid_o;
  assign wr_fire = aw_held && w_held;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr_i;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_held <= 1'b1;
      w_byte <= s_axi_wdata_i[7:0];
      w_lane0 <= s_axi_wstrb_i[0];
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  logic wr_map;
  always_comb begin
    case (aw_addr)
      OFS_STACK_PTR, OFS_TOP_LOW, OFS_TOP_HIGH, OFS_TOP_UPPER, OFS_CONTROL: wr_map = 1'b1;
      default: wr_map = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= wr_map ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  logic sw_wr;
  assign sw_wr = wr_fire && w_lane0;

  // ==========================================================
  // Stack sequencing
  logic core_op;
  logic [PTR_W-1:0] next_sp;
  logic set_full;
  logic set_unf;
  logic next_fault;
  logic ent_wr;
  logic [PTR_W-1:0] ent_idx;
  logic [PC_W-1:0] ent_val;

  assign core_op = core_req_i.push || core_req_i.pop || core_req_i.discard;

  always_comb begin
    next_sp = sp;
    set_full = 1'b0;
    set_unf = 1'b0;
    next_fault = 1'b0;
    ent_wr = 1'b0;
    ent_idx = sp;
    ent_val = core_req_i.pc;
    if (core_req_i.push) begin
      if (sp == PTR_NEAR_TOP) begin
        ent_wr = 1'b1;
        ent_idx = PTR_TOP;
        set_full = 1'b1; // [RULE6]
        if (fault_en) begin
          ent_val = core_req_i.pc + PC_STEP; // [RULE7]
          next_fault = 1'b1; // [RULE11]
          next_sp = PTR_EMPTY;
        end else begin
          next_sp = PTR_TOP; // [RULE8]
        end
      end else if (sp == PTR_TOP) begin
        // Overflowing push is dropped so entry 31 survives
        set_full = 1'b1; // [RULE8]
        if (fault_en) begin
          next_fault = 1'b1; // [RULE11]
          next_sp = PTR_EMPTY;
        end
      end else begin
        ent_wr = 1'b1;
        ent_idx = sp + 5'h01; // [RULE5] [RULE14]
        next_sp = sp + 5'h01; // [RULE2]
      end
    end else if (core_req_i.pop || core_req_i.discard) begin
      if (sp == PTR_EMPTY) begin
        set_unf = 1'b1; // [RULE9]
        next_fault = fault_en; // [RULE10] [RULE11]
      end else begin
        next_sp = sp - 5'h01; // [RULE5] [RULE15]
      end
    end else if (sw_wr && aw_addr == OFS_STACK_PTR) begin
      next_sp = w_byte[PTR_W-1:0]; // [RULE4]
    end
    if (dev_rst_i) begin
      next_sp = PTR_EMPTY; // [RULE4]
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sp <= PTR_EMPTY; // [RULE4]
    end else begin
      sp <= next_sp;
    end
  end

  // Core access wins; a colliding software byte write is lost
  always_ff @(posedge clk_i) begin
    if (ent_wr) begin
      entries[ent_idx] <= ent_val;
    end else if (!core_op && sw_wr && sp != PTR_EMPTY) begin
      case (aw_addr)
        OFS_TOP_LOW: entries[sp][7:0] <= w_byte; // [RULE1]
        OFS_TOP_HIGH: entries[sp][15:8] <= w_byte;
        OFS_TOP_UPPER: entries[sp][20:16] <= w_byte[4:0];
        default: ;
      endcase
    end
  end

  // Set beats clear; flags survive device resets, only a software zero write or power-on clears
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      full_flag <= 1'b0;
      unf_flag <= 1'b0;
    end else begin
      if (set_full) begin
        full_flag <= 1'b1;
      end else if (sw_wr && aw_addr == OFS_STACK_PTR && !w_byte[FULL_BIT]) begin
        full_flag <= 1'b0; // [RULE12] [RULE22]
      end
      if (set_unf) begin
        unf_flag <= 1'b1;
      end else if (sw_wr && aw_addr == OFS_STACK_PTR && !w_byte[UNF_BIT]) begin
        unf_flag <= 1'b0; // [RULE12] [RULE22]
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fault_en <= FAULT_EN_RESET;
    end else if (sw_wr && aw_addr == OFS_CONTROL) begin
      fault_en <= w_byte[FAULT_EN_BIT];
    end
  end

  // Reset request rises on the same edge as the flag update
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fault_reset_o <= 1'b0;
    end else begin
      fault_reset_o <= next_fault; // [RULE11]
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ret_valid_o <= 1'b0;
      ret_pc_o <= PC_ZERO;
    end else begin
      ret_valid_o <= core_req_i.pop;
      if (core_req_i.pop) begin
        ret_pc_o <= top_entry; // [RULE21] [RULE9]
      end
    end
  end

  // ==========================================================
  // Fast shadow context, invisible to software
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      shadow <= '0;
    end else if (core_req_i.push && (core_req_i.vector || core_req_i.fast)) begin
      shadow <= ctx_i; // [RULE16] [RULE18]
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctx_restore_o <= 1'b0;
      ctx_o <= '0;
    end else begin
      ctx_restore_o <= core_req_i.pop && core_req_i.fast;
      if (core_req_i.pop && core_req_i.fast) begin
        ctx_o <= shadow; // [RULE17] [RULE18]
      end
    end
  end

  // ==========================================================
  // Bus read channel
  logic [7:0] rd_byte;
  logic rd_map;
  always_comb begin
    rd_byte = 8'h00;
    rd_map = 1'b1;
    case (s_axi_araddr_i)
      OFS_STACK_PTR: rd_byte = {full_flag, unf_flag, 1'b0, sp}; // [RULE13]
      OFS_TOP_LOW: rd_byte = top_entry[7:0];
      OFS_TOP_HIGH: rd_byte = top_entry[15:8];
      OFS_TOP_UPPER: rd_byte = {3'h0, top_entry[20:16]};
      OFS_CONTROL: rd_byte = {7'h00, fault_en};
      default: rd_map = 1'b0;
    endcase
  end

  assign s_axi_arready_o = !s_axi_rvalid_o;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= {24'h000000, rd_byte};
      s_axi_rresp_o <= rd_map ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  logic quiet;
  assign quiet = !dev_rst_i;

  chk_push_visible: assert property ( // [RULE2]
    core_req_i.push && sp < PTR_NEAR_TOP && quiet |=> top_entry == $past(core_req_i.pc))
    else $error("pushed address not at top");
  chk_sp_increment: assert property ( // [RULE5]
    core_req_i.push && sp < PTR_NEAR_TOP && quiet |=> sp == $past(sp) + 5'h01)
    else $error("push did not advance pointer");
  chk_full_flag_set: assert property ( // [RULE6]
    core_req_i.push && sp == PTR_NEAR_TOP |=> full_flag)
    else $error("full flag missing after 31st push");
  chk_overflow_reset: assert property ( // [RULE7]
    core_req_i.push && sp == PTR_NEAR_TOP && fault_en && quiet
    |=> sp == PTR_EMPTY && full_flag && fault_reset_o && entries[31] == $past(core_req_i.pc) + PC_STEP)
    else $error("overflow reset sequence wrong");
  chk_full_hold: assert property ( // [RULE8]
    core_req_i.push && sp == PTR_TOP && !fault_en && quiet |=> sp == PTR_TOP && $stable(entries[31]))
    else $error("full stack altered by push");
  chk_underflow_pop: assert property ( // [RULE9]
    core_req_i.pop && sp == PTR_EMPTY && quiet |=> ret_valid_o && ret_pc_o == PC_ZERO && unf_flag && sp == PTR_EMPTY)
    else $error("underflow pop wrong");
  chk_no_silent_reset: assert property ( // [RULE10]
    (core_req_i.pop || core_req_i.discard) && sp == PTR_EMPTY && !fault_en |=> !fault_reset_o)
    else $error("reset raised with fault reset off");
  chk_flag_sticky: assert property ( // [RULE12]
    full_flag && !(sw_wr && aw_addr == OFS_STACK_PTR) |=> full_flag)
    else $error("full flag cleared without write");
  chk_pop_order: assert property ( // [RULE21]
    core_req_i.pop && sp != PTR_EMPTY && quiet |=> ret_pc_o == $past(top_entry) && sp == $past(sp) - 5'h01)
    else $error("pop order wrong");
  chk_fast_restore: assert property ( // [RULE17]
    core_req_i.pop && core_req_i.fast |=> ctx_restore_o && ctx_o == $past(shadow))
    else $error("fast return did not restore context");
  chk_bit5_zero: assert property ( // [RULE13]
    s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == OFS_STACK_PTR |=> s_axi_rdata_o[5] == 1'b0)
    else $error("reserved bit read nonzero");

  cov_overflow: cover property (core_req_i.push && sp == PTR_NEAR_TOP);
  cov_underflow: cover property (core_req_i.pop && sp == PTR_EMPTY);
  cov_fast_pair: cover property (core_req_i.push && core_req_i.fast ##[1:20] core_req_i.pop && core_req_i.fast);
  cov_sw_top_write: cover property (sw_wr && aw_addr == OFS_TOP_LOW && sp != PTR_EMPTY);

endmodule // ras_stack

// File: test/ras_core_model.sv
// Sequencer-side model issuing one-cycle stack commands and holding live context
`timescale 1ns/1ps
module ras_core_model
  import ras_pkg::*;
(
  input wire logic clk_i,
  output ras_core_req_t req_o,
  output ras_ctx_t ctx_o
);
  // ==========================================================
  // Commands
  // Callers keep interrupts masked around top-entry access
  // One priority level only, so one shadow level is enough
  initial begin
    req_o = '0;
    ctx_o = '0;
  end
  // Kind bits: push, pop, discard, vector, fast
  task automatic cmd(input logic [4:0] kind, input logic [PC_W-1:0] pc);
    @(posedge clk_i);
    req_o <= {kind, pc};
    @(posedge clk_i);
    req_o <= '0;
  endtask
  task automatic set_ctx(input logic [23:0] v);
    @(posedge clk_i);
    ctx_o <= v;
  endtask
endmodule // ras_core_model

// File: test/return_address_stack_unit_tb.sv
// Self-checking bench of the return address stack over its register bus and core port
`timescale 1ns/1ps
module return_address_stack_unit_tb;
  import ras_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic dev_rst_i = 1'b0;
  ras_core_req_t req;
  ras_ctx_t ctx_in;
  ras_ctx_t ctx_out;
  logic ret_valid, ctx_restore, fault;
  logic [PC_W-1:0] ret_pc;
  logic [4:0] awaddr = '0;
  logic [4:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rdat;
  logic [1:0] rsp, bsp;
  logic [3:0] strb = 4'hF;
  int rets = 0;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  int faults = 0;
  int restores = 0;

  always #10 clk_i = ~clk_i;

  ras_stack DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .dev_rst_i(dev_rst_i), .core_req_i(req), .ctx_i(ctx_in),
    .ret_valid_o(ret_valid), .ret_pc_o(ret_pc), .ctx_restore_o(ctx_restore), .ctx_o(ctx_out),
    .fault_reset_o(fault), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(strb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));

  ras_core_model core (.clk_i(clk_i), .req_o(req), .ctx_o(ctx_in));

  // ==========================================================
  // Pulse counters and hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (fault === 1'b1) faults++;
    if (ctx_restore === 1'b1) restores++;
    if (ret_valid === 1'b1) rets++;
    if (cycles > 3000) begin
      mismatches++;
      end_of_test();
    end
  end

  // ==========================================================
  // Bus tasks
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a);
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rdat = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
    rd(a);
    chk(rdat, exp);
  endtask

  task automatic end_of_test();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================
  // Tests
  initial begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rdchk(OFS_STACK_PTR, 32'h00);
    rdchk(OFS_CONTROL, 32'h01);
    core.cmd(5'h10, 21'h000111);
    core.cmd(5'h10, 21'h000222);
    core.cmd(5'h10, 21'h1ABCDE);
    rdchk(OFS_STACK_PTR, 32'h03);
    rdchk(OFS_TOP_LOW, 32'hDE);
    rdchk(OFS_TOP_HIGH, 32'hBC);
    rdchk(OFS_TOP_UPPER, 32'h1A);
    wr(OFS_TOP_LOW, 8'h54);
    chk({30'h0, bsp}, {30'h0, RESP_OKAY});
    core.cmd(5'h08, PC_ZERO);
    rdchk(OFS_STACK_PTR, 32'h02);
    chk({11'h000, ret_pc}, 32'h001ABC54);
    core.cmd(5'h04, PC_ZERO);
    rdchk(OFS_TOP_LOW, 32'h11);
    $display("test push_pop done");
    core.set_ctx(24'hA1B2C3);
    core.cmd(5'h12, 21'h000444);
    core.set_ctx(24'h5A5A5A);
    core.cmd(5'h09, PC_ZERO);
    rdchk(OFS_STACK_PTR, 32'h01);
    chk({8'h00, ctx_out}, 32'h00A1B2C3);
    chk(restores, 32'h1);
    core.set_ctx(24'h112233);
    core.cmd(5'h11, 21'h000666);
    core.set_ctx(24'h5A5A5A);
    core.cmd(5'h09, PC_ZERO);
    rdchk(OFS_STACK_PTR, 32'h01);
    chk({8'h00, ctx_out}, 32'h00112233);
    chk(restores, 32'h2);
    $display("test shadow done");
    core.cmd(5'h08, PC_ZERO);
    core.cmd(5'h08, PC_ZERO);
    rdchk(OFS_STACK_PTR, 32'h40);
    chk({11'h000, ret_pc}, 32'h0);
    chk(faults, 32'h1);
    wr(OFS_CONTROL, 8'h00);
    core.cmd(5'h08, PC_ZERO);
    rdchk(OFS_STACK_PTR, 32'h40);
    chk(faults, 32'h1);
    chk(rets, 32'h6);
    wr(OFS_STACK_PTR, 8'hC3);
    rdchk(OFS_STACK_PTR, 32'h43);
    @(posedge clk_i);
    dev_rst_i <= 1'b1;
    @(posedge clk_i);
    dev_rst_i <= 1'b0;
    rdchk(OFS_STACK_PTR, 32'h40);
    wr(OFS_STACK_PTR, 8'h00);
    rdchk(OFS_STACK_PTR, 32'h00);
    // Lane 0 disabled: the pointer write must be ignored
    strb <= 4'h0;
    wr(OFS_STACK_PTR, 8'h05);
    strb <= 4'hF;
    rdchk(OFS_STACK_PTR, 32'h00);
    $display("test underflow done");
    wr(OFS_STACK_PTR, 8'h3E);
    rdchk(OFS_STACK_PTR, 32'h1E);
    core.cmd(5'h10, 21'h000777);
    rdchk(OFS_STACK_PTR, 32'h9F);
    core.cmd(5'h10, 21'h000888);
    rdchk(OFS_STACK_PTR, 32'h9F);
    rdchk(OFS_TOP_LOW, 32'h77);
    wr(OFS_STACK_PTR, 8'h1E);
    rdchk(OFS_STACK_PTR, 32'h1E);
    wr(OFS_CONTROL, 8'h01);
    core.cmd(5'h10, 21'h000999);
    rdchk(OFS_STACK_PTR, 32'h80);
    chk(faults, 32'h2);
    wr(OFS_STACK_PTR, 8'h9F);
    rdchk(OFS_STACK_PTR, 32'h9F);
    rdchk(OFS_TOP_LOW, 32'h9B);
    wr(5'h14, 8'hFF);
    chk({30'h0, bsp}, {30'h0, RESP_SLVERR});
    rdchk(5'h14, 32'h00);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    rdchk(OFS_STACK_PTR, 32'h9F);
    // Push on a full stack with fault reset on still requests a reset
    core.cmd(5'h10, 21'h000AAA);
    rdchk(OFS_STACK_PTR, 32'h80);
    chk(faults, 32'h3);
    core.cmd(5'h04, PC_ZERO);
    rdchk(OFS_STACK_PTR, 32'hC0);
    chk(faults, 32'h4);
    $display("test overflow done");
    end_of_test();
  end
endmodule // return_address_stack_unit_tb
